//--- dv/ocr_config_assertions.sv
`timescale 1ns/1ps
module ocr_chk (
    input wire logic        clk_i, rst_i, wr_en_i, memory_size_flag_i,
    input wire logic [31:0] wr_data_i, rd_data_o,
    input wire logic [3:0]  slot_number_i,
    input wire logic [5:0]  irq_vec_low_i,
    input wire logic [7:0]  irq_vec_o, mem_wr_data_i, bus_out_data_i,
    input wire logic        mem_wr_par_o, bus_out_par_o, core_reset_o,
    input wire logic        router_side_reset_o, sum_tree_drive_en_o,
    input wire logic        mem_par_err_o, bus_par_err_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wr;
        wr_en_i ##1 1'b1;
    endsequence
    a_slot_read: assert property (rd_data_o[31:28] == slot_number_i)
        else $error("slot");
    a_size_read: assert property (rd_data_o[27] == memory_size_flag_i)
        else $error("size");
    a_write_take: assert property (s_wr |->
        rd_data_o[9:0] == $past(wr_data_i[9:0])) else $error("write");
    a_ctrl_hold: assert property (!wr_en_i |=> $stable(rd_data_o[9:0]))
        else $error("hold");
    a_reset_lines: assert property ({core_reset_o, router_side_reset_o,
        sum_tree_drive_en_o} == ~{rd_data_o[0], rd_data_o[8],
        rd_data_o[5]}) else $error("ctrl");
    a_vector_base: assert property (irq_vec_o ==
        {rd_data_o[7:6], irq_vec_low_i}) else $error("vector");
    a_par_gen: assert property ({mem_wr_par_o, bus_out_par_o} ==
        {^{mem_wr_data_i, rd_data_o[4]}, ~^bus_out_data_i}) else $error("par");
    a_mem_mask: assert property (mem_par_err_o |->
        $past(rd_data_o[3] & rd_data_o[0])) else $error("mem err");
    a_bus_mask: assert property (bus_par_err_o |-> $past(rd_data_o[2]))
        else $error("bus err");
endmodule : ocr_chk

//--- dv/ocr_host.sv
`timescale 1ns/1ps
module ocr_host (
    input  wire logic        clk_i, go_i,
    input  wire logic [31:0] dat_i,
    output logic             wr_en_o,
    output logic      [31:0] wr_data_o
);
    // Strobe lasts one cycle because go_i is a one-cycle request
    always_ff @(posedge clk_i) begin
        wr_en_o   <= go_i;
        wr_data_o <= dat_i;
    end
endmodule : ocr_host

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 0, rst_i = 1, go = 0, wr_en, iv = 0, mv = 0, mp = 0, bp = 0;
    logic [31:0] dat = 0, wr_data, rd;
    logic [7:0]  md = 0, bd = 0, vec;
    logic [3:0]  slot = 4'ha;
    logic        msz = 1'b1;
    logic        mpar, bpar, merr, berr, cr, rr, se;
    int fail_count = 0, tests_run = 0, cyc = 0;
    always #20 clk_i = ~clk_i;
    ocr_host host_u (.clk_i(clk_i), .go_i(go), .dat_i(dat), .wr_en_o(wr_en),
        .wr_data_o(wr_data));
    ocr_config dut_u (.clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en),
        .wr_data_i(wr_data), .rd_data_o(rd), .slot_number_i(slot),
        .memory_size_flag_i(msz), .irq_vec_low_i(6'h15), .irq_vec_o(vec),
        .mem_wr_data_i(md), .mem_wr_par_o(mpar), .mem_rd_data_i(md),
        .mem_rd_par_i(mp), .mem_rd_valid_i(mv), .mem_par_err_o(merr),
        .bus_out_data_i(bd), .bus_out_par_o(bpar), .bus_in_data_i(bd),
        .bus_in_par_i(bp), .bus_in_valid_i(iv), .bus_par_err_o(berr),
        .core_reset_o(cr), .router_side_reset_o(rr), .sum_tree_drive_en_o(se));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [31:0] d);
        @(posedge clk_i) begin go <= 1; dat <= d; end
        @(posedge clk_i) go <= 0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask : wr
    // Pulse the valid strobe on one checker input for one cycle; m picks memory, else bus
    task automatic pulse(input logic m, input logic [1:0] e);
        @(posedge clk_i) begin mv <= m; iv <= !m; end
        @(posedge clk_i) begin mv <= 0; iv <= 0; end
        #1 chk({merr, berr}, e);
    endtask : pulse
    task automatic t_reset;
        chk(rd, 32'ha800_0000);
        chk({cr, rr, se}, 3'h7);
    endtask : t_reset
    task automatic t_all_set;
        wr(32'hffff_ffff);
        chk(rd, 32'ha800_03ff);
        chk({cr, rr, se, vec}, 11'h0d5);
        @(posedge clk_i) begin md <= 8'h01; bd <= 8'h01; mp <= 1; bp <= 1; end
        #1 chk({mpar, bpar}, 2'h0);
        pulse(1, 2'h2);
        pulse(0, 2'h1);
    endtask : t_all_set
    task automatic t_checks_off;
        wr(32'h0000_0000);
        chk({mpar, bpar}, 2'h2);
        wr(32'h0000_0011);
        pulse(1, 2'h0);
        pulse(0, 2'h0);
        wr(32'h0000_0008);
        pulse(1, 2'h0);
        @(posedge clk_i) begin slot <= 4'h5; msz <= 1'b0; end
        #1 chk(rd, 32'h5000_0008);
        @(posedge clk_i) begin slot <= 4'ha; msz <= 1'b1; end
    endtask : t_checks_off
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 400) begin fail_count++; end_of_test(); end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        #1 t_reset();
        t_all_set();
        t_checks_off();
        @(posedge clk_i) rst_i <= 1;
        @(posedge clk_i) rst_i <= 0;
        #1 t_reset();
        end_of_test();
    end
endmodule : tb_top
bind ocr_config ocr_chk chk_u (.*);

//--- logic/ocr_config.sv
`timescale 1ns/1ps
module ocr_config (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Register access
    input  wire logic        wr_en_i,
    input  wire logic [31:0] wr_data_i,
    output logic      [31:0] rd_data_o,
    // Board straps
    input  wire logic [3:0]  slot_number_i,
    input  wire logic        memory_size_flag_i,
    // Interrupt vector
    input  wire logic [5:0]  irq_vec_low_i,
    output logic      [7:0]  irq_vec_o,
    // Buffer memory parity
    input  wire logic [7:0]  mem_wr_data_i,
    output logic             mem_wr_par_o,
    input  wire logic [7:0]  mem_rd_data_i,
    input  wire logic        mem_rd_par_i,
    input  wire logic        mem_rd_valid_i,
    output logic             mem_par_err_o,
    // System bus parity
    input  wire logic [7:0]  bus_out_data_i,
    output logic             bus_out_par_o,
    input  wire logic [7:0]  bus_in_data_i,
    input  wire logic        bus_in_par_i,
    input  wire logic        bus_in_valid_i,
    output logic             bus_par_err_o,
    // Resets and router controls
    output logic             core_reset_o,
    output logic             router_side_reset_o,
    output logic             sum_tree_drive_en_o
);
    logic [9:0] ctrl_ff;
    logic [9:0] nxt_ctrl;
    logic       mem_err_ff;
    logic       nxt_mem_err;
    logic       bus_err_ff;
    logic       nxt_bus_err;
    logic       mem_chk_err;
    logic       bus_chk_err;

    wire logic core_run = ctrl_ff[ocr_pkg::CORE_RST_BIT];

    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_en_i) begin
            // Only the low ten bits are storage
            nxt_ctrl = wr_data_i[9:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= ocr_pkg::CTRL_RESET;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    always_comb begin
        rd_data_o = ocr_pkg::UNUSED_VAL & ~ocr_pkg::WR_MASK;
        rd_data_o[ocr_pkg::SLOT_HI:ocr_pkg::SLOT_LO] = slot_number_i;
        rd_data_o[ocr_pkg::MEM_SIZE_BIT] = memory_size_flag_i;
        rd_data_o[9:0] = ctrl_ff;
    end

    always_comb begin
        irq_vec_o = {ctrl_ff[ocr_pkg::VEC_HI:ocr_pkg::VEC_LO],
                     irq_vec_low_i};
        core_reset_o        = ~core_run;
        router_side_reset_o = ~ctrl_ff[ocr_pkg::RTR_RST_BIT];
        sum_tree_drive_en_o = ~ctrl_ff[ocr_pkg::SUM_DIS_BIT];
    end

    // Memory side, polarity chosen by software for diagnostics
    ocr_parity #(.W(8)) u_mem_wr (
        .data_i   (mem_wr_data_i),
        .odd_i    (ctrl_ff[ocr_pkg::PAR_POL_BIT]),
        .par_i    (1'b0),
        .chk_en_i (1'b0),
        .par_o    (mem_wr_par_o),
        .err_o    ()
    );
    ocr_parity #(.W(8)) u_mem_rd (
        .data_i   (mem_rd_data_i),
        .odd_i    (ctrl_ff[ocr_pkg::PAR_POL_BIT]),
        .par_i    (mem_rd_par_i),
        .chk_en_i (ctrl_ff[ocr_pkg::MEM_PCHK_BIT] & mem_rd_valid_i),
        .par_o    (),
        .err_o    (mem_chk_err)
    );
    // Bus side uses odd parity; generation never gated
    ocr_parity #(.W(8)) u_bus_out (
        .data_i   (bus_out_data_i),
        .odd_i    (1'b1),
        .par_i    (1'b0),
        .chk_en_i (1'b0),
        .par_o    (bus_out_par_o),
        .err_o    ()
    );
    ocr_parity #(.W(8)) u_bus_in (
        .data_i   (bus_in_data_i),
        .odd_i    (1'b1),
        .par_i    (bus_in_par_i),
        .chk_en_i (ctrl_ff[ocr_pkg::BUS_PCHK_BIT] & bus_in_valid_i),
        .par_o    (),
        .err_o    (bus_chk_err)
    );

    always_comb begin
        // Memory checker belongs to the core and is held by core reset
        nxt_mem_err = core_run & mem_chk_err;
        nxt_bus_err = bus_chk_err;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_err_ff <= 1'b0;
            bus_err_ff <= 1'b0;
        end else begin
            mem_err_ff <= nxt_mem_err;
            bus_err_ff <= nxt_bus_err;
        end
    end

    assign mem_par_err_o = mem_err_ff;
    assign bus_par_err_o = bus_err_ff;
endmodule : ocr_config

//--- logic/ocr_parity.sv
`timescale 1ns/1ps
// Byte parity generator and checker with selectable polarity
module ocr_parity #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] data_i,
    input  wire logic         odd_i,
    input  wire logic         par_i,
    input  wire logic         chk_en_i,
    output logic              par_o,
    output logic              err_o
);
    always_comb begin
        par_o = (^data_i) ^ odd_i;
        err_o = chk_en_i & (par_o != par_i);
    end
endmodule : ocr_parity

//--- logic/ocr_pkg.sv
package ocr_pkg;
    // Field positions within the configuration word
    localparam int SLOT_HI      = 31;
    localparam int SLOT_LO      = 28;
    localparam int MEM_SIZE_BIT = 27;
    localparam int STEP_BIT     = 9;
    localparam int RTR_RST_BIT  = 8;
    localparam int VEC_HI       = 7;
    localparam int VEC_LO       = 6;
    localparam int SUM_DIS_BIT  = 5;
    localparam int PAR_POL_BIT  = 4;
    localparam int MEM_PCHK_BIT = 3;
    localparam int BUS_PCHK_BIT = 2;
    localparam int GATE_N_BIT   = 1;
    localparam int CORE_RST_BIT = 0;
    // Writable bits, all clear on system reset
    localparam logic [9:0]  CTRL_RESET = 10'h000;
    localparam logic [31:0] WR_MASK    = 32'h0000_03ff;
    // Unused and spare bits read as this fixed filler
    localparam logic [31:0] UNUSED_VAL = 32'h0000_0000;
    localparam int VEC_LOW_W = 6;
endpackage : ocr_pkg
